// ---- logic/vom_monitor.sv ----
// overcurrent fault monitor and fault pin driver for six mosfets
// How it works
// - deglitch select 00/01/10/11 gives 0, 1.75, 3.5, 7 us persistence.
// - blanking select gives 0, 1.75, 3.5, 7 us ignore after switching.
// - warning drives fault pin low as one 56 us pulse.
// - any fault pulls fault pin low and latches cause in status.
// - each of six mosfets has its own overcurrent status bit.
// - with both selects 00, gates off and fault within 1 us.
`timescale 1ns/10ps
`include "vom_consts.svh"
module vom_monitor #(
  parameter int NFET = 6,
  parameter int WARN_CYC = `VOM_WARN_PULSE_CYC,
  parameter int READY_CYC = `VOM_READY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // configuration
  input wire vom_pkg::vom_cfg_t cfg,
  // analog side
  input wire logic [NFET-1:0] cmp_trip,
  input wire logic [NFET-1:0] gate_switch,
  output logic [4:0] trip_level_code,
  // events and host controls
  input wire logic warn_evt,
  input wire logic status_clear,
  // status to the serial interface
  output vom_pkg::vom_status_t status,
  output logic gates_off,
  // open-drain fault pin
  input wire logic fault_out_n_di,
  output logic fault_out_n_do,
  output logic fault_out_n_oe,
  output logic fault_pin_low
);
  localparam int TW = `VOM_TMR_W;
  localparam int WW = $clog2(WARN_CYC + 1);
  localparam int RW = $clog2(READY_CYC + 1);
  localparam logic [WW-1:0] WARN_LAST = WW'(WARN_CYC - 1);
  localparam logic [RW-1:0] READY_LAST = RW'(READY_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_ff, rst_sync_ff;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selector decode, shared by blanking and deglitch
  function automatic logic [TW-1:0] sel_to_cyc(input logic [1:0] sel);
    case (sel)
      `VOM_SEL_NONE: sel_to_cyc = '0;
      `VOM_SEL_SHORT: sel_to_cyc = TW'(`VOM_CYC_SHORT);
      `VOM_SEL_MID: sel_to_cyc = TW'(`VOM_CYC_MID);
      default: sel_to_cyc = TW'(`VOM_CYC_LONG);
    endcase
  endfunction : sel_to_cyc

  logic [TW-1:0] blank_cyc, degl_cyc;
  assign blank_cyc = sel_to_cyc(cfg.overcurrent_blank_sel);
  assign degl_cyc = sel_to_cyc(cfg.overcurrent_deglitch_sel);

  logic [NFET-1:0] trip;

  genvar gi;
  generate
    for (gi = 0; gi < NFET; gi++)
    begin : g_fet
      vom_fet_filter #(.TW(TW)) u_filt (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_ff),
        .cmp_trip(cmp_trip[gi]),
        .gate_switch(gate_switch[gi]),
        .blank_cyc(blank_cyc),
        .degl_cyc(degl_cyc),
        .trip(trip[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault status, warning pulse, ready timer
  logic [NFET-1:0] oc_ff, nxt_oc;
  logic gates_off_ff, nxt_gates_off;
  logic oe_ff, nxt_oe;
  logic do_ff, nxt_do;
  logic pin_low_ff, nxt_pin_low;
  logic [4:0] level_ff, nxt_level;
  vom_pkg::vom_warn_state_t warn_st_ff, nxt_warn_st;
  logic [WW-1:0] warn_cnt_ff, nxt_warn_cnt;
  logic [RW-1:0] ready_cnt_ff, nxt_ready_cnt;
  logic ready_ff, nxt_ready;

  always_comb
  begin
    // set wins over a clear in the same cycle
    nxt_oc = (status_clear ? '0 : oc_ff) | trip;
    nxt_gates_off = |nxt_oc;
    // summary indication: latched faults hold it, warnings pulse it
    nxt_oe = (|nxt_oc) || (nxt_warn_st == vom_pkg::VOM_WARN_PULSE);
    // open drain: only ever pulled low, the external pull-up gives the high
    nxt_do = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      oc_ff <= '0;
      gates_off_ff <= 1'b0;
      oe_ff <= 1'b0;
      do_ff <= 1'b0;
    end
    else
    begin
      oc_ff <= nxt_oc;
      gates_off_ff <= nxt_gates_off;
      oe_ff <= nxt_oe;
      do_ff <= nxt_do;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // warning pulse
  always_comb
  begin
    nxt_warn_st = warn_st_ff;
    nxt_warn_cnt = warn_cnt_ff;
    case (warn_st_ff)
      vom_pkg::VOM_WARN_IDLE:
      begin
        if (warn_evt)
        begin
          nxt_warn_st = vom_pkg::VOM_WARN_PULSE;
          nxt_warn_cnt = '0;
        end
      end
      vom_pkg::VOM_WARN_PULSE:
      begin
        // pulse length fixed; repeated warnings inside it are absorbed
        if (warn_cnt_ff == WARN_LAST)
        begin
          nxt_warn_st = vom_pkg::VOM_WARN_IDLE;
        end
        else
        begin
          nxt_warn_cnt = warn_cnt_ff + 1'b1;
        end
      end
      default:
      begin
        nxt_warn_st = vom_pkg::VOM_WARN_IDLE;
        nxt_warn_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      warn_st_ff <= vom_pkg::VOM_WARN_IDLE;
      warn_cnt_ff <= '0;
    end
    else
    begin
      warn_st_ff <= nxt_warn_st;
      warn_cnt_ff <= nxt_warn_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sample and trip level
  always_comb
  begin
    nxt_pin_low = !fault_out_n_di;
    // top code aliases the one below it
    if (cfg.drain_source_trip_level == `VOM_LEVEL_TOP)
    begin
      nxt_level = `VOM_LEVEL_MAX;
    end
    else
    begin
      nxt_level = cfg.drain_source_trip_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      pin_low_ff <= 1'b0;
      level_ff <= '0;
    end
    else
    begin
      pin_low_ff <= nxt_pin_low;
      level_ff <= nxt_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready timer
  always_comb
  begin
    // status reads are valid only once this flag rises
    nxt_ready_cnt = ready_cnt_ff;
    nxt_ready = ready_ff;
    if (ready_cnt_ff == READY_LAST)
    begin
      nxt_ready = 1'b1;
    end
    else
    begin
      nxt_ready_cnt = ready_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      ready_cnt_ff <= '0;
      ready_ff <= 1'b0;
    end
    else
    begin
      ready_cnt_ff <= nxt_ready_cnt;
      ready_ff <= nxt_ready;
    end
  end

  // one driver for the whole status word
  assign status = vom_pkg::vom_status_t'({oc_ff, ready_ff});
  assign gates_off = gates_off_ff;
  assign fault_out_n_oe = oe_ff;
  assign fault_out_n_do = do_ff;
  assign fault_pin_low = pin_low_ff;
  assign trip_level_code = level_ff;
endmodule : vom_monitor

// ---- logic/vom_consts.svh ----
// timing and code constants for the overcurrent monitor
`ifndef VOM_CONSTS_SVH
`define VOM_CONSTS_SVH
`define VOM_CLK_PERIOD_NS 8
`define VOM_TIME_SHORT_NS 1750
`define VOM_TIME_MID_NS 3500
`define VOM_TIME_LONG_NS 7000
`define VOM_CYC_SHORT ((`VOM_TIME_SHORT_NS + `VOM_CLK_PERIOD_NS - 1) / `VOM_CLK_PERIOD_NS)
`define VOM_CYC_MID ((`VOM_TIME_MID_NS + `VOM_CLK_PERIOD_NS - 1) / `VOM_CLK_PERIOD_NS)
`define VOM_CYC_LONG ((`VOM_TIME_LONG_NS + `VOM_CLK_PERIOD_NS - 1) / `VOM_CLK_PERIOD_NS)
`define VOM_WARN_PULSE_US 56
`define VOM_WARN_PULSE_CYC ((`VOM_WARN_PULSE_US * 1000) / `VOM_CLK_PERIOD_NS)
`define VOM_READY_MS 10
`define VOM_READY_CYC ((`VOM_READY_MS * 1000000 + `VOM_CLK_PERIOD_NS - 1) / `VOM_CLK_PERIOD_NS)
`define VOM_SEL_NONE 2'h0
`define VOM_SEL_SHORT 2'h1
`define VOM_SEL_MID 2'h2
`define VOM_LEVEL_TOP 5'h1F
`define VOM_LEVEL_MAX 5'h1E
`define VOM_TMR_W 10
`endif

// ---- logic/vom_pkg.sv ----
// types shared by the overcurrent monitor
package vom_pkg;
  typedef struct packed {
    logic [1:0] overcurrent_deglitch_sel;
    logic [1:0] overcurrent_blank_sel;
    logic [4:0] drain_source_trip_level;
  } vom_cfg_t;

  typedef struct packed {
    logic [5:0] oc_fault;
    logic spi_ready;
  } vom_status_t;

  typedef enum logic [1:0] {
    VOM_WARN_IDLE = 2'b01,
    VOM_WARN_PULSE = 2'b10
  } vom_warn_state_t;
endpackage : vom_pkg

// ---- logic/vom_fet_filter.sv ----
// blanking and deglitch filter for one mosfet comparator
`timescale 1ns/10ps
`include "vom_consts.svh"
module vom_fet_filter #(
  parameter int TW = `VOM_TMR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // comparator and switching
  input wire logic cmp_trip,
  input wire logic gate_switch,
  // windows in cycles, zero means off
  input wire logic [TW-1:0] blank_cyc,
  input wire logic [TW-1:0] degl_cyc,
  // qualified trip, high every cycle while the comparator stays qualified
  output logic trip
);
  logic [TW-1:0] blank_ff, nxt_blank;
  logic [TW-1:0] degl_ff, nxt_degl;
  logic trip_ff, nxt_trip;

  always_comb
  begin
    nxt_blank = blank_ff;
    nxt_degl = degl_ff;
    nxt_trip = 1'b0;
    if (gate_switch)
    begin
      nxt_blank = blank_cyc;
    end
    else if (blank_ff != '0)
    begin
      nxt_blank = blank_ff - 1'b1;
    end
    // blanked comparator restarts the deglitch window
    if (gate_switch && blank_cyc != '0 || blank_ff != '0 || !cmp_trip)
    begin
      nxt_degl = '0;
    end
    else if (degl_ff >= degl_cyc)
    begin
      nxt_trip = 1'b1;
    end
    else
    begin
      nxt_degl = degl_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blank_ff <= '0;
      degl_ff <= '0;
      trip_ff <= 1'b0;
    end
    else
    begin
      blank_ff <= nxt_blank;
      degl_ff <= nxt_degl;
      trip_ff <= nxt_trip;
    end
  end

  assign trip = trip_ff;
endmodule : vom_fet_filter

// ---- verif/vom_assertions.sv ----
// port checker for the overcurrent monitor
`timescale 1ns/10ps
module vom_assertions #(
  parameter int NFET = 6,
  parameter int WARN_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vom_pkg::vom_cfg_t cfg,
  input wire logic [NFET-1:0] cmp_trip,
  input wire logic warn_evt,
  input wire logic status_clear,
  input wire vom_pkg::vom_status_t status,
  input wire logic gates_off,
  input wire logic fault_out_n_di,
  input wire logic fault_out_n_do,
  input wire logic fault_out_n_oe,
  input wire logic [4:0] trip_level_code,
  input wire logic fault_pin_low
);
  logic [15:0] run_ff;
  logic [15:0] nxt_run;
  logic [4:0] lvl;
  logic rdy;
  assign rdy = status.spi_ready;
  assign lvl = (cfg[4:0] == 5'h1F) ? 5'h1E : cfg[4:0];
  // a fault also holds the line, so only fault-free cycles count
  always_comb
  begin
    nxt_run = (fault_out_n_oe && status.oc_fault == 6'h00) ? run_ff + 16'h1 : 16'h0;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      run_ff <= 16'h0;
    else
      run_ff <= nxt_run;
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_level_clamp:
  assert property (rdy && $stable(lvl) |-> trip_level_code == lvl) else $error("level");
  a_fast_trip:
  assert property (rdy && cfg[8:5] == 4'h0 && cmp_trip != '0 |-> ##[1:3] status.oc_fault != 6'h00)
    else $error("trip");
  a_fault_drive:
  assert property (status.oc_fault != 6'h00 |-> gates_off && fault_out_n_oe) else $error("drive");
  a_drive_zero:
  assert property (!fault_out_n_do) else $error("level one");
  a_warn_start:
  assert property (rdy && warn_evt && !fault_out_n_oe |=> fault_out_n_oe) else $error("warn");
  a_warn_len:
  assert property ($fell(fault_out_n_oe) && $past(status.oc_fault) == 6'h00 |-> run_ff == WARN_CYC)
    else $error("length");
  a_fault_sticky:
  assert property (rdy && !$past(status_clear)
    |-> ($past(status.oc_fault) & ~status.oc_fault) == 6'h00)
    else $error("sticky");
  a_pin_echo:
  assert property (rdy |-> fault_pin_low == !$past(fault_out_n_di)) else $error("echo");
endmodule : vom_assertions

// ---- verif/vom_host_model.sv ----
// host side: pulled-up fault line and clearing status reads
`timescale 1ns/10ps
module vom_host_model (
  input wire logic sys_clk,
  input wire logic fault_out_n_do,
  input wire logic fault_out_n_oe,
  input wire vom_pkg::vom_status_t status,
  input wire logic rd_req,
  output logic fault_line_n,
  output logic status_clear,
  output logic [5:0] rd_data
);
  // released line floats up to the pull-up level
  assign fault_line_n = (fault_out_n_oe === 1'b1) ? fault_out_n_do : 1'b1;
  always @(posedge sys_clk)
  begin
    status_clear <= 1'b0;
    if (rd_req && status.spi_ready && !status_clear)
    begin
      rd_data <= status.oc_fault;
      status_clear <= 1'b1;
    end
  end
endmodule : vom_host_model

// ---- verif/vom_monitor_tb_top.sv ----
// self-checking bench for the overcurrent monitor
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("BAD %0t %0h %0h", $time, a, b); \
    end \
  end
module vom_monitor_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  vom_pkg::vom_cfg_t cfg = 9'h000;
  logic [5:0] cmp_trip = 6'h00;
  logic [5:0] gate_switch = 6'h00;
  logic warn_evt = 1'b0;
  logic rd_req = 1'b0;
  logic status_clear;
  logic fault_line_n;
  logic gates_off;
  logic fault_out_n_do;
  logic fault_out_n_oe;
  logic fault_pin_low;
  logic [4:0] trip_level_code;
  logic [5:0] rd_data;
  vom_pkg::vom_status_t status;
  // bench model: expected sticky faults and the reads still owed
  logic [5:0] model_oc = 6'h00;
  logic [5:0] exp_q[$];
  logic [5:0] exp_rd;
  int errors = 0;
  int samples_checked = 0;
  int dly[4] = '{0, 219, 438, 875};
  int f;
  int n;
  logic [7:0] seed = 8'h3A;
  always #4 sys_clk = ~sys_clk;
  vom_monitor #(.WARN_CYC(20), .READY_CYC(50)) vom_monitor_i (.sys_clk, .nrst, .cfg,
    .cmp_trip, .gate_switch, .trip_level_code, .warn_evt, .status_clear, .status, .gates_off,
    .fault_out_n_di(fault_line_n), .fault_out_n_do, .fault_out_n_oe, .fault_pin_low);
  vom_host_model vom_host_model_i (.sys_clk, .fault_out_n_do, .fault_out_n_oe, .status,
    .rd_req, .fault_line_n, .status_clear, .rd_data);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  // hold one comparator for c sampled cycles, then let it settle
  task automatic trip(input int c, input logic sw);
    cmp_trip[f] <= 1'b1;
    gate_switch[f] <= sw;
    tick(1);
    gate_switch <= 6'h00;
    tick(c - 1);
    cmp_trip <= 6'h00;
    tick(4);
  endtask : trip
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    tick(10);
    nrst <= 1'b1;
    n = 0;
    while (status.spi_ready !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    `CHK(n inside {[50:56]}, 1'b1)
    $display("ready test done");
    for (int v = 0; v < 32; v++)
    begin
      cfg.drain_source_trip_level <= 5'(v);
      tick(3);
      `CHK(trip_level_code, (v == 31) ? 5'h1E : 5'(v))
    end
    $display("level test done");
    // k 0..3 walk the deglitch codes, 4..6 the blanking codes
    for (int k = 0; k < 7; k++)
    begin
      seed = lfsr(seed);
      f = seed % 6;
      n = (k < 4) ? dly[k] : dly[k - 3] + 1;
      cfg.overcurrent_deglitch_sel <= (k < 4) ? 2'(k) : 2'h0;
      cfg.overcurrent_blank_sel <= (k < 4) ? 2'h0 : 2'(k - 3);
      tick(1);
      // switching edge every time: blank code 00 must not mask the trip
      if (n > 0)
      begin
        trip(n, 1'b1);
        `CHK(status.oc_fault, model_oc)
      end
      trip(n + 1, 1'b1);
      model_oc = model_oc | (6'h01 << f);
      `CHK(status.oc_fault, model_oc)
      `CHK(fault_line_n, 1'b0)
      `CHK(fault_pin_low, 1'b1)
      `CHK(gates_off, 1'b1)
      exp_q.push_back(model_oc);
      model_oc = 6'h00;
      rd_req <= 1'b1;
      tick(1);
      rd_req <= 1'b0;
      tick(3);
      exp_rd = exp_q.pop_front();
      `CHK(rd_data, exp_rd)
      `CHK(status.oc_fault, model_oc)
      `CHK(fault_pin_low, 1'b0)
      `CHK(gates_off, 1'b0)
    end
    $display("trip tests done");
    warn_evt <= 1'b1;
    tick(1);
    warn_evt <= 1'b0;
    tick(1);
    n = 0;
    // a second request mid-pulse must not stretch it
    while (fault_line_n === 1'b0 && n < 100)
    begin
      warn_evt <= (n == 5);
      n++;
      tick(1);
    end
    `CHK(n, 20)
    $display("warning test done");
    wrap_up();
  end
  initial
  begin
    #(8 * 20000);
    errors++;
    wrap_up();
  end
endmodule : vom_monitor_tb_top
bind vom_monitor vom_assertions #(.NFET(NFET), .WARN_CYC(WARN_CYC)) vom_assertions_i (.sys_clk,
  .nrst, .cfg, .cmp_trip, .warn_evt, .status_clear, .status, .gates_off, .fault_out_n_di,
  .fault_out_n_do, .fault_out_n_oe, .trip_level_code, .fault_pin_low);
